// ### pkg/acss_params.svh
// Functional notes
// - Strapped mode: range pin low selects wide span, high selects narrow span.
// - Register mode with clock-source bit: conversion clock comes in on shared pin.
// - Register mode with clock-drive-out bit and clock-source bit clear: internal conversion clock driven on pin.
// - Status-mode bit clear: status pin is a busy indicator.
// - Busy mode: status pin goes active as soon as a conversion starts.
// - Busy mode: one clock-period inactive pulse per pair done, inactive after last.
// - Status-mode bit set: status pin is an interrupt output.
// - Interrupt mode: assert after conversion completes, hold until next read access.
// - Polarity bit inverts active level of the status pin.
// - Rising edge of a pair trigger starts conversion of both channels of that pair.
// - Pair A trigger resets channel sequencer so next read returns first A channel.
// - Mode-select low: settings come from external configuration pins.
// - Mode-select high: settings come from the configuration register.
`ifndef ACSS_PARAMS_SVH
`define ACSS_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ACSS_ADDR_W 4
`define ACSS_REG_CONFIG 4'h0
`define ACSS_REG_STATUS 4'h1
`define ACSS_REG_IRQ_STAT 4'h2
`define ACSS_REG_IRQ_MASK 4'h3
`define ACSS_REG_CHAN 4'h4
`define ACSS_REG_ID 4'h5

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define ACSS_CFG_CLKSRC_BIT 29
`define ACSS_CFG_CLKDRV_BIT 28
`define ACSS_CFG_STATMODE_BIT 27
`define ACSS_CFG_POL_BIT 26
`define ACSS_CFG_RANGE_BIT 24
`define ACSS_CFG_RESET 32'h0000_0000
// Arbitrary identification value
`define ACSS_ID_VALUE 32'h00a5_0001

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACSS_CLK_MHZ 100
`define ACSS_CONV_TIME_NS 1000
`define ACSS_CONV_CYCLES ((`ACSS_CONV_TIME_NS * `ACSS_CLK_MHZ + 999) / 1000)
`define ACSS_CCLK_DIV 4
`define ACSS_CNT_W 8
`define ACSS_NPAIR 4

`endif

// ### pkg/acss_pkg.sv
`include "acss_params.svh"
package acss_pkg;
  typedef struct packed {
    logic [`ACSS_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } acss_bus_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } acss_pin_out_t;

  typedef enum logic [1:0] {
    ACSS_IDLE,
    ACSS_CONV,
    ACSS_GAP
  } acss_pair_state_t;
endpackage : acss_pkg

// ### hw/acss_pair_conv.sv
`include "acss_params.svh"
module acss_pair_conv (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic cclk_tick_in,
  output logic busy_out,
  output logic done_out
);
  import acss_pkg::*;

  acss_pair_state_t state_q;
  logic [`ACSS_CNT_W-1:0] cnt_q;

  // ----------------------------------------
  // Conversion timer
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q <= ACSS_IDLE;
      cnt_q <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state_q)
        ACSS_IDLE: begin
          if (start_in) begin
            state_q <= ACSS_CONV;
            cnt_q <= '0;
          end
        end
        ACSS_CONV: begin
          if (cclk_tick_in) begin
            if (cnt_q == `ACSS_CNT_W'(`ACSS_CONV_CYCLES / `ACSS_CCLK_DIV - 1)) begin
              state_q <= ACSS_IDLE;
              done_out <= 1'b1;
            end else begin
              cnt_q <= cnt_q + `ACSS_CNT_W'(1);
            end
          end
        end
        default: state_q <= ACSS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) busy_out <= 1'b0;
    else busy_out <= (state_q == ACSS_CONV) && !done_out;
  end
endmodule : acss_pair_conv

// ### hw/acss_top.sv
`include "acss_params.svh"
module acss_top (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [`ACSS_NPAIR-1:0] pair_trigger_in,
  input wire logic setup_source_select_in,
  input wire logic span_or_clock_pin_in,
  input wire logic strap_status_mode_in,
  input wire logic strap_polarity_in,
  input wire logic data_read_in,
  input wire acss_pkg::acss_bus_req_t bus_in,
  output logic [31:0] rdata_out,
  output acss_pkg::acss_pin_out_t span_or_clock_pin_out,
  output logic status_pin_out,
  output logic narrow_span_out,
  output logic ext_clock_used_out,
  output logic [2:0] chan_index_out,
  output logic irq_out
);
  import acss_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [`ACSS_NPAIR-1:0] trig_m_q, trig_s_q, trig_p_q;
  logic [4:0] misc_m_q, misc_s_q;
  logic sel_reg, pin_lvl, stat_mode_pin, pol_pin, rd_sync;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      trig_m_q <= '0;
      trig_s_q <= '0;
      trig_p_q <= '0;
      misc_m_q <= '0;
      misc_s_q <= '0;
    end else begin
      trig_m_q <= pair_trigger_in;
      trig_s_q <= trig_m_q;
      trig_p_q <= trig_s_q;
      misc_m_q <= {data_read_in, strap_polarity_in, strap_status_mode_in,
                   span_or_clock_pin_in, setup_source_select_in};
      misc_s_q <= misc_m_q;
    end
  end

  assign sel_reg = misc_s_q[0];
  assign pin_lvl = misc_s_q[1];
  assign stat_mode_pin = misc_s_q[2];
  assign pol_pin = misc_s_q[3];
  assign rd_sync = misc_s_q[4];

  logic [`ACSS_NPAIR-1:0] trig_rise;
  assign trig_rise = trig_s_q & ~trig_p_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] config_q;
  logic [`ACSS_NPAIR:0] irq_stat_q, irq_mask_q;
  logic [`ACSS_NPAIR:0] irq_ev;
  logic rd_stat;

  function automatic logic addr_hit(input logic [`ACSS_ADDR_W-1:0] a,
                                    input logic [`ACSS_ADDR_W-1:0] r);
    return a == r;
  endfunction : addr_hit

  assign rd_stat = bus_in.rd && addr_hit(bus_in.addr, `ACSS_REG_IRQ_STAT);

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) config_q <= `ACSS_CFG_RESET;
    else if (bus_in.wr && addr_hit(bus_in.addr, `ACSS_REG_CONFIG)) config_q <= bus_in.wdata;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) irq_mask_q <= '0;
    else if (bus_in.wr && addr_hit(bus_in.addr, `ACSS_REG_IRQ_MASK))
      irq_mask_q <= bus_in.wdata[`ACSS_NPAIR:0];
  end

  // Set wins over read clear
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) irq_stat_q <= '0;
    else if (rd_stat) irq_stat_q <= irq_ev;
    else irq_stat_q <= irq_stat_q | irq_ev;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) irq_out <= 1'b0;
    else irq_out <= |((irq_stat_q | irq_ev) & irq_mask_q & ~({5{rd_stat}} & ~irq_ev));
  end

  // ----------------------------------------
  // Effective settings
  // ----------------------------------------
  logic clk_src, clk_drv, stat_mode, pol, narrow;
  assign clk_src = sel_reg & config_q[`ACSS_CFG_CLKSRC_BIT];
  assign clk_drv = sel_reg & config_q[`ACSS_CFG_CLKDRV_BIT] & ~clk_src;
  assign stat_mode = sel_reg ? config_q[`ACSS_CFG_STATMODE_BIT] : stat_mode_pin;
  assign pol = sel_reg ? config_q[`ACSS_CFG_POL_BIT] : pol_pin;
  assign narrow = sel_reg ? config_q[`ACSS_CFG_RANGE_BIT] : pin_lvl;

  // ----------------------------------------
  // Conversion clock
  // ----------------------------------------
  logic [1:0] div_q;
  logic int_cclk_q, ext_prev_q, cclk_tick;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      div_q <= '0;
      int_cclk_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h1 || div_q == 2'h3) int_cclk_q <= ~int_cclk_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) ext_prev_q <= 1'b0;
    else ext_prev_q <= pin_lvl;
  end

  assign cclk_tick = clk_src ? (pin_lvl & ~ext_prev_q) : (div_q == 2'h3);

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) span_or_clock_pin_out <= '0;
    else span_or_clock_pin_out <= '{o: int_cclk_q & clk_drv, oe: clk_drv};
  end

  // ----------------------------------------
  // Pair converters
  // ----------------------------------------
  logic [`ACSS_NPAIR-1:0] busy, done;

  for (genvar i = 0; i < `ACSS_NPAIR; i++) begin : g_pair
    acss_pair_conv u_conv (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .start_in(trig_rise[i]),
      .cclk_tick_in(cclk_tick),
      .busy_out(busy[i]),
      .done_out(done[i])
    );
  end

  logic all_done;
  assign all_done = |done & ~|(busy & ~done);
  assign irq_ev = {all_done, done};

  // ----------------------------------------
  // Status pin
  // ----------------------------------------
  logic busy_lvl_q, int_lvl_q, rd_prev_q, read_acc;
  logic [2:0] gap_q;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) rd_prev_q <= 1'b0;
    else rd_prev_q <= rd_sync;
  end
  assign read_acc = rd_sync & ~rd_prev_q;

  // Four reference clocks (one internal conversion clock period) low after each pair
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) gap_q <= '0;
    else if (|done) gap_q <= 3'(`ACSS_CCLK_DIV);
    else if (gap_q != 3'h0) gap_q <= gap_q - 3'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) busy_lvl_q <= 1'b0;
    else if (|trig_rise) busy_lvl_q <= 1'b1;
    else if (|done) busy_lvl_q <= 1'b0;
    else if (gap_q == 3'h1 && |busy) busy_lvl_q <= 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) int_lvl_q <= 1'b0;
    else if (all_done) int_lvl_q <= 1'b1;
    else if (read_acc) int_lvl_q <= 1'b0;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) status_pin_out <= 1'b0;
    else status_pin_out <= (stat_mode ? int_lvl_q : busy_lvl_q) ^ pol;
  end

  // ----------------------------------------
  // Channel sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) chan_index_out <= 3'h0;
    else if (trig_rise[0]) chan_index_out <= 3'h0;
    else if (read_acc) chan_index_out <= chan_index_out + 3'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      narrow_span_out <= 1'b0;
      ext_clock_used_out <= 1'b0;
    end else begin
      narrow_span_out <= narrow;
      ext_clock_used_out <= clk_src;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) rdata_out <= '0;
    else if (bus_in.rd) begin
      unique case (bus_in.addr)
        `ACSS_REG_CONFIG: rdata_out <= config_q;
        `ACSS_REG_STATUS: rdata_out <= {24'h0, 1'b0, status_pin_out, int_lvl_q,
                                        busy_lvl_q, busy};
        `ACSS_REG_IRQ_STAT: rdata_out <= {27'h0, irq_stat_q};
        `ACSS_REG_IRQ_MASK: rdata_out <= {27'h0, irq_mask_q};
        `ACSS_REG_CHAN: rdata_out <= {29'h0, chan_index_out};
        `ACSS_REG_ID: rdata_out <= `ACSS_ID_VALUE;
        default: rdata_out <= 32'h0;
      endcase
    end else rdata_out <= 32'h0;
  end
endmodule : acss_top

// ### test/acss_top_sva.sv
`include "acss_params.svh"
module acss_top_sva (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [`ACSS_NPAIR-1:0] pair_trigger_in,
  input wire logic setup_source_select_in,
  input wire logic span_or_clock_pin_in,
  input wire logic strap_status_mode_in,
  input wire logic strap_polarity_in,
  input wire logic data_read_in,
  input wire acss_pkg::acss_bus_req_t bus_in,
  input wire logic [31:0] rdata_out,
  input wire acss_pkg::acss_pin_out_t span_or_clock_pin_out,
  input wire logic status_pin_out,
  input wire logic narrow_span_out,
  input wire logic ext_clock_used_out,
  input wire logic [2:0] chan_index_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import acss_pkg::*;
  logic busy_m;
  logic int_m;
  assign busy_m = !setup_source_select_in && !strap_status_mode_in && !strap_polarity_in;
  assign int_m = !setup_source_select_in && strap_status_mode_in && !strap_polarity_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_busy_fall;
    busy_m && $fell(status_pin_out);
  endsequence
  sequence s_low_gap;
    (!status_pin_out)[*4];
  endsequence
  a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
    else $error("read data not zero outside read slot");
  a_clock_excl: assert property (!(span_or_clock_pin_out.oe && ext_clock_used_out))
    else $error("shared pin driven while used as clock input");
  a_strap_noclk: assert property ((!setup_source_select_in)[*5] |->
    !ext_clock_used_out && !span_or_clock_pin_out.oe)
    else $error("clock function active in strapped mode");
  a_strap_narrow: assert property ((!setup_source_select_in && span_or_clock_pin_in)[*6]
    |-> narrow_span_out)
    else $error("narrow span not selected");
  a_strap_wide: assert property ((!setup_source_select_in && !span_or_clock_pin_in)[*6]
    |-> !narrow_span_out)
    else $error("wide span not selected");
  a_chan_restart: assert property ($rose(pair_trigger_in[0]) |-> ##[1:8] chan_index_out == 3'h0)
    else $error("channel sequencer not restarted");
  a_busy_start: assert property (busy_m && $rose(pair_trigger_in[0]) |-> ##[1:8] status_pin_out)
    else $error("busy not raised after start");
  a_busy_gap: assert property (s_busy_fall |-> s_low_gap)
    else $error("busy low pulse too short");
  a_busy_ends: assert property (busy_m && $rose(status_pin_out) |-> ##[1:400] !status_pin_out)
    else $error("busy never released");
  a_int_hold: assert property (int_m && $fell(status_pin_out) |-> $past(data_read_in) ||
    $past(data_read_in, 2) || $past(data_read_in, 3) || $past(data_read_in, 4))
    else $error("interrupt dropped without read");
endmodule : acss_top_sva

// ### test/acss_host_model.sv
`include "acss_params.svh"
module acss_host_model (
  input wire logic ref_clk_in,
  output logic [`ACSS_NPAIR-1:0] pair_trigger_out,
  output logic data_read_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pair_trigger_out = '0;
    data_read_out = 1'b0;
  end
  // Rising trigger edge, held for hold clocks
  task automatic convert(input logic [3:0] pairs, input int hold);
    @(posedge ref_clk_in);
    pair_trigger_out <= pairs;
    repeat (hold) @(posedge ref_clk_in);
    pair_trigger_out <= '0;
  endtask : convert
  task automatic read_access(input int hold);
    @(posedge ref_clk_in);
    data_read_out <= 1'b1;
    repeat (hold) @(posedge ref_clk_in);
    data_read_out <= 1'b0;
  endtask : read_access
endmodule : acss_host_model

// ### test/tb_acss_top.sv
`include "acss_params.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_acss_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acss_pkg::*;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] trig;
  logic sel = 1'b0, span = 1'b0, smode = 1'b0, spol = 1'b0, rd_acc;
  acss_bus_req_t bus_in = '0;
  logic [31:0] rdata_out, d;
  acss_pin_out_t pin_out;
  logic status_pin_out, narrow, ext, irq;
  logic [2:0] chan;
  int num_errors = 0, checked = 0, cycles = 0;
  acss_host_model i_host (.ref_clk_in(ref_clk_in), .pair_trigger_out(trig),
    .data_read_out(rd_acc));
  acss_top i_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .pair_trigger_in(trig),
    .setup_source_select_in(sel), .span_or_clock_pin_in(span), .strap_status_mode_in(smode),
    .strap_polarity_in(spol), .data_read_in(rd_acc), .bus_in(bus_in), .rdata_out(rdata_out),
    .span_or_clock_pin_out(pin_out), .status_pin_out(status_pin_out), .narrow_span_out(narrow),
    .ext_clock_used_out(ext), .chan_index_out(chan), .irq_out(irq));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_in <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1 d = rdata_out;
  endtask : rd
  task automatic wait_pin(input logic v, input int lim);
    int n;
    n = 0;
    while (status_pin_out !== v && n < lim) begin
      @(posedge ref_clk_in);
      n++;
    end
    #1;
  endtask : wait_pin
  task automatic t_strap;
    cyc(8);
    `CHK("narrow", 1'b0, narrow)
    span <= 1'b1;
    cyc(8);
    `CHK("narrow", 1'b1, narrow)
    `CHK("pin_oe", 1'b0, pin_out.oe)
  endtask : t_strap
  task automatic t_regs;
    wr(4'h0, 32'h0100_0000);
    sel <= 1'b1;
    span <= 1'b0;
    cyc(8);
    `CHK("narrow", 1'b1, narrow)
    rd(4'h0);
    `CHK("config", 32'h0100_0000, d)
    wr(4'h0, 32'h1000_0000);
    cyc(8);
    `CHK("pin_oe", 1'b1, pin_out.oe)
    `CHK("ext", 1'b0, ext)
    wr(4'h0, 32'h3000_0000);
    cyc(8);
    `CHK("ext", 1'b1, ext)
    `CHK("pin_oe", 1'b0, pin_out.oe)
    wr(4'h0, 32'h0400_0000);
    cyc(8);
    `CHK("status", 1'b1, status_pin_out)
    wr(4'h0, 32'h0);
    rd(4'hf);
    `CHK("unmapped", 32'h0, d)
    sel <= 1'b0;
    cyc(8);
  endtask : t_regs
  task automatic t_busy;
    i_host.convert(4'hf, 3);
    wait_pin(1'b1, 20);
    `CHK("busy", 1'b1, status_pin_out)
    wait_pin(1'b0, 500);
    cyc(20);
    `CHK("busy", 1'b0, status_pin_out)
    `CHK("irq", 1'b0, irq)
    wr(4'h3, 32'h1f);
    cyc(2);
    `CHK("irq", 1'b1, irq)
    wr(4'h3, 32'h0);
    rd(4'h2);
    `CHK("irq_stat", 5'h1f, d[4:0])
    rd(4'h2);
    `CHK("irq_stat", 32'h0, d)
    `CHK("irq", 1'b0, irq)
  endtask : t_busy
  task automatic t_chan;
    repeat (3) i_host.read_access(3);
    cyc(8);
    `CHK("chan", 3'h3, chan)
    rd(4'h4);
    `CHK("chan_reg", 32'h3, d)
    i_host.convert(4'h1, 2);
    cyc(8);
    `CHK("chan", 3'h0, chan)
    wait_pin(1'b0, 500);
  endtask : t_chan
  task automatic t_gap;
    i_host.convert(4'h1, 1);
    cyc(8);
    i_host.convert(4'h2, 1);
    wait_pin(1'b0, 500);
    `CHK("gap", 1'b0, status_pin_out)
    cyc(2);
    `CHK("gap", 1'b0, status_pin_out)
    wait_pin(1'b1, 10);
    `CHK("gap_end", 1'b1, status_pin_out)
    wait_pin(1'b0, 500);
    cyc(10);
    `CHK("last", 1'b0, status_pin_out)
  endtask : t_gap
  task automatic t_int;
    i_host.read_access(1);
    smode <= 1'b1;
    cyc(4);
    `CHK("int", 1'b0, status_pin_out)
    i_host.convert(4'hf, 3);
    cyc(30);
    `CHK("int", 1'b0, status_pin_out)
    wait_pin(1'b1, 500);
    `CHK("int", 1'b1, status_pin_out)
    i_host.read_access(3);
    wait_pin(1'b0, 10);
    `CHK("int", 1'b0, status_pin_out)
    spol <= 1'b1;
    cyc(8);
    `CHK("int_pol", 1'b1, status_pin_out)
    spol <= 1'b0;
    smode <= 1'b0;
    cyc(8);
  endtask : t_int
  task automatic end_of_test;
    $display("TB: checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    cyc(8);
    resetn_in <= 1'b1;
    cyc(2);
    t_strap();
    t_regs();
    t_busy();
    t_chan();
    t_gap();
    t_int();
    end_of_test();
  end
endmodule : tb_acss_top
bind acss_top acss_top_sva i_sva (.*);
